// >>> rtl/sdt_framer.v
/*
 * Slave-diagnostic telegram framer: APB registers, station status
 * bytes and byte-serial emission of the diagnostic telegram.
 * Assumes pclk at 250 MHz, APB master on the same clock, and a bus
 * engine that takes one byte per tx_valid/tx_ready handshake.
 */
// The address map and the APB slave port were left to the implementer.
// Operation
// R1 - Status byte 1 bit 0 shows that the slave needs new parameters.
// R2 - Status byte 1 bit 1 shows a pending static diagnostic condition.
// R3 - Status byte 1 bit 2 always reads one while the slave is present.
// R4 - Status byte 1 bit 3 shows that response monitoring is on.
// R5 - Status byte 1 bits 4 and 5 latch received FREEZE and SYNC.
// R6 - Status byte 1 bit 7 shows the slave excluded from cyclic work.
// R7 - Status byte 1 bit 6 and status byte 2 bits 0..6 are zero.
// R8 - Status byte 2 bit 7 shows lost diagnostic messages.
// R9 - Byte 3 holds the configuring master address, ff if none.
// R10 - Bytes 4 and 5 hold a fixed two-byte maker code, byte 4 first.
// R11 - Module status starts with module diagnostics, at most 13 bytes.
// R12 - Interrupt status starts at byte y, at most 20 bytes.
// R13 - Process interrupt has code 02 at y+1 and 4 info bytes from y+4.
// R14 - Diagnostic interrupt has code 01, 16 bytes from y+4, last 12 zero.
// R15 - Status byte 0 bit 3 is one for run-to-stop, zero for stop-to-run.
// R16 - Bytes go out in ascending order, header, module, interrupt.
// R17 - The master reads whole telegrams and keeps every message.
`timescale 1ns/1ps
`include "sdt_regs.vh"
module sdt_framer #(
	parameter [7:0] MAKER_HI = 8'h5a, // Arbitrary identity value
	parameter [7:0] MAKER_LO = 8'ha5  // Arbitrary identity value
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        freeze_in,
	input  wire        sync_in,
	output reg  [7:0]  tx_data,
	output reg         tx_valid,
	output reg         tx_last,
	input  wire        tx_ready,
	output reg         irq
);

	// ************************************************************
	// Pin synchronisers and edge detect
	// ************************************************************
	reg [1:0] frz_s_q;
	reg [1:0] syn_s_q;
	reg       frz_d_q;
	reg       syn_d_q;
	wire      frz_ev = frz_s_q[1] & ~frz_d_q;
	wire      syn_ev = syn_s_q[1] & ~syn_d_q;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			frz_s_q <= 2'h0;
			syn_s_q <= 2'h0;
			frz_d_q <= 1'b0;
			syn_d_q <= 1'b0;
		end
		else
		begin
			frz_s_q <= {frz_s_q[0], freeze_in};
			syn_s_q <= {syn_s_q[0], sync_in};
			frz_d_q <= frz_s_q[1];
			syn_d_q <= syn_s_q[1];
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	reg  [4:0]  ctrl_q;
	reg  [7:0]  maddr_q;
	reg  [3:0]  irq_q;
	reg  [3:0]  mask_q;
	reg  [31:0] pinfo_q;
	reg  [31:0] dinfo_q;
	reg  [3:0]  modlen_q;
	reg         frz_q;
	reg         syn_q;
	reg         ovf_q;
	reg  [1:0]  pend_q;
	reg         busy_q;

	// Writes land at the completing edge, read clears at data capture
	wire wr_acc = psel & penable & pwrite & pready;
	wire rd_acc = psel & penable & ~pwrite & ~pready;

	function map_ok;
		input [11:0] a;
		begin
			map_ok = (a <= `SDT_SEND_OFS) && (a[1:0] == 2'h0);
		end
	endfunction

	function is_reg;
		input [11:0] a;
		input [11:0] ofs;
		begin
			is_reg = (a == ofs);
		end
	endfunction

	wire wr_send = wr_acc & is_reg(paddr, `SDT_SEND_OFS);
	wire [1:0] send_cmd = pwdata[1:0];
	wire send_ok = wr_send && (send_cmd != `SDT_SEND_NONE) &&
		(send_cmd != 2'h3);
	// A request while one is waiting would overwrite it: count as lost
	wire lost = send_ok & (pend_q != `SDT_SEND_NONE); // [R8]
	wire start = (pend_q != `SDT_SEND_NONE) & ~busy_q;
	wire done_ev;
	wire rd_irq = rd_acc & is_reg(paddr, `SDT_IRQ_OFS);
	wire [3:0] ev = {syn_ev, frz_ev, lost, done_ev};

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q   <= 5'h04;
			maddr_q  <= `SDT_NO_MASTER; // [R9]
			mask_q   <= 4'h0;
			pinfo_q  <= 32'h0;
			dinfo_q  <= 32'h0;
			modlen_q <= 4'h0;
			frz_q    <= 1'b0;
			syn_q    <= 1'b0;
			ovf_q    <= 1'b0;
			irq_q    <= 4'h0;
			pend_q   <= `SDT_SEND_NONE;
		end
		else
		begin
			if (wr_acc && is_reg(paddr, `SDT_CTRL_OFS))
				ctrl_q <= pwdata[4:0]; // [R1] [R2] [R4] [R6] [R15]
			if (wr_acc && is_reg(paddr, `SDT_MADDR_OFS))
				maddr_q <= pwdata[7:0]; // [R9]
			if (wr_acc && is_reg(paddr, `SDT_IMASK_OFS))
				mask_q <= pwdata[3:0];
			if (wr_acc && is_reg(paddr, `SDT_PINFO_OFS))
				pinfo_q <= pwdata;
			if (wr_acc && is_reg(paddr, `SDT_DINFO_OFS))
				dinfo_q <= pwdata;
			if (wr_acc && is_reg(paddr, `SDT_MODLEN_OFS))
				modlen_q <= (pwdata[7:0] > `SDT_MOD_MAX) ?
					4'hd : pwdata[3:0]; // [R11]
			// Status write-one clears; a new event wins
			if (wr_acc && is_reg(paddr, `SDT_STAT_OFS))
			begin
				frz_q <= (frz_q & ~pwdata[0]) | frz_ev;
				syn_q <= (syn_q & ~pwdata[1]) | syn_ev;
				ovf_q <= (ovf_q & ~pwdata[2]) | lost;
			end
			else
			begin
				frz_q <= frz_q | frz_ev; // [R5]
				syn_q <= syn_q | syn_ev; // [R5]
				ovf_q <= ovf_q | lost; // [R8]
			end
			irq_q <= (rd_irq ? 4'h0 : irq_q) | ev;
			if (send_ok)
				pend_q <= send_cmd;
			else if (start)
				pend_q <= `SDT_SEND_NONE;
		end
	end

	// ************************************************************
	// Module status memory
	// ************************************************************
	wire       mod_we = wr_acc & is_reg(paddr, `SDT_MODDAT_OFS);
	wire [3:0] mod_raddr;
	wire [7:0] mod_rdata;

	sdt_mem #(
		.AW (4),
		.DW (8)
	) u_mem (
		.clk     (pclk),
		.we      (mod_we),
		.waddr   (pwdata[11:8]),
		.wdata   (pwdata[7:0]),
		.raddr   (mod_raddr),
		.rdata_q (mod_rdata)
	);

	// ************************************************************
	// Telegram sequencer
	// ************************************************************
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_HDR  = 2'h1;
	localparam [1:0] ST_MOD  = 2'h2;
	localparam [1:0] ST_INT  = 2'h3;

	reg  [1:0] st_q;
	reg  [7:0] idx_q;
	reg  [1:0] kind_q;
	reg  [31:0] snap_q;
	reg  [7:0] hdr [0:5];
	reg  [7:0] ib;
	reg  [7:0] ilen;

	// Station status bytes built live from control and latches
	always @*
	begin
		hdr[0] = {4'h0, ctrl_q[`SDT_CTRL_RUNSTOP] &
			(kind_q == `SDT_SEND_DIAG), 3'h0}; // [R15]
		hdr[1] = {ctrl_q[`SDT_CTRL_DISABLE], 1'b0, syn_q, frz_q,
			ctrl_q[`SDT_CTRL_RESPMON], 1'b1,
			ctrl_q[`SDT_CTRL_STATIC],
			ctrl_q[`SDT_CTRL_REPARAM]}; // [R1] [R2] [R3] [R4] [R5] [R6] [R7]
		hdr[2] = {ovf_q, 7'h00}; // [R7] [R8]
		hdr[3] = maddr_q; // [R9]
		hdr[4] = MAKER_HI; // [R10]
		hdr[5] = MAKER_LO; // [R10]
	end

	// Interrupt section: length byte, code, slot, spec, then body
	always @*
	begin
		ilen = (kind_q == `SDT_SEND_PROC) ? 8'h08 : 8'h14; // [R12]
		case (idx_q)
		8'h00: ib = ilen;
		8'h01: ib = (kind_q == `SDT_SEND_PROC) ?
			`SDT_PROC_CODE : `SDT_DIAG_CODE; // [R13] [R14]
		8'h02: ib = 8'h00;
		8'h03: ib = 8'h00;
		8'h04: ib = snap_q[31:24];
		8'h05: ib = snap_q[23:16];
		8'h06: ib = snap_q[15:8];
		8'h07: ib = snap_q[7:0];
		default: ib = 8'h00; // [R14]
		endcase
	end

	wire step = tx_valid & tx_ready;
	wire int_end = (st_q == ST_INT) && (idx_q == ilen - 8'h01);
	assign done_ev = step & tx_last;
	// Memory address is the index of the next byte to load
	assign mod_raddr = (st_q == ST_MOD) ?
		idx_q[3:0] : 4'h0;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q     <= ST_IDLE;
			idx_q    <= 8'h00;
			kind_q   <= `SDT_SEND_NONE;
			snap_q   <= 32'h0;
			busy_q   <= 1'b0;
			tx_valid <= 1'b0;
			tx_last  <= 1'b0;
			tx_data  <= 8'h00;
		end
		else
		begin
			case (st_q)
			ST_IDLE:
			begin
				if (start)
				begin
					kind_q   <= pend_q;
					snap_q   <= (pend_q == `SDT_SEND_PROC) ?
						pinfo_q : dinfo_q;
					busy_q   <= 1'b1;
					st_q     <= ST_HDR;
					idx_q    <= 8'h00;
				end
			end
			ST_HDR:
			begin
				if (!tx_valid || step)
				begin
					tx_valid <= 1'b1;
					tx_data  <= hdr[idx_q[2:0]]; // [R16]
					if (idx_q == `SDT_HDR_LEN - 8'h01)
					begin
						idx_q <= 8'h00;
						st_q  <= (modlen_q == 4'h0) ? ST_INT : ST_MOD;
					end
					else
						idx_q <= idx_q + 8'h01;
				end
			end
			ST_MOD:
			begin
				// Wait one cycle for registered memory data
				if (step)
				begin
					tx_valid <= 1'b0;
				end
				else if (!tx_valid)
				begin
					tx_valid <= 1'b1;
					tx_data  <= mod_rdata; // [R11] [R16]
					if (idx_q[3:0] == modlen_q - 4'h1)
					begin
						idx_q <= 8'h00;
						st_q  <= ST_INT;
					end
					else
						idx_q <= idx_q + 8'h01;
				end
			end
			default:
			begin
				if (step && tx_last)
				begin
					tx_valid <= 1'b0;
					tx_last  <= 1'b0;
					busy_q   <= 1'b0;
					st_q     <= ST_IDLE;
					idx_q    <= 8'h00;
				end
				else if (!tx_valid || (step && !tx_last))
				begin
					tx_valid <= 1'b1;
					tx_data  <= ib; // [R12] [R13] [R14] [R16]
					tx_last  <= int_end;
					idx_q    <= idx_q + 8'h01;
				end
			end
			endcase
		end
	end

	// ************************************************************
	// APB read path and interrupt output
	// ************************************************************
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			irq     <= 1'b0;
		end
		else
		begin
			// One wait state: answer lands in the access cycle after
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~map_ok(paddr);
			prdata  <= 32'h0;
			if (psel && penable && !pready && !pwrite)
			begin
				case (paddr)
				`SDT_CTRL_OFS:   prdata <= {27'h0, ctrl_q};
				`SDT_STAT_OFS:   prdata <= {8'h0, hdr[2], hdr[1],
					5'h0, ovf_q, syn_q, frz_q};
				`SDT_MADDR_OFS:  prdata <= {24'h0, maddr_q};
				`SDT_IRQ_OFS:    prdata <= {28'h0, irq_q};
				`SDT_IMASK_OFS:  prdata <= {28'h0, mask_q};
				`SDT_PINFO_OFS:  prdata <= pinfo_q;
				`SDT_DINFO_OFS:  prdata <= dinfo_q;
				`SDT_MODLEN_OFS: prdata <= {28'h0, modlen_q};
				`SDT_SEND_OFS:   prdata <= {29'h0, busy_q, pend_q};
				default:         prdata <= 32'h0;
				endcase
			end
			irq <= |(irq_q & mask_q);
		end
	end
endmodule // sdt_framer

// >>> rtl/sdt_regs.vh
/*
 * Register offsets, field positions, codes and limits of the
 * slave-diagnostic telegram framer.
 * Assumes inclusion by bare name from the rtl/ design files.
 */
`ifndef SDT_REGS_VH
`define SDT_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SDT_CTRL_OFS     12'h000
`define SDT_STAT_OFS     12'h004
`define SDT_MADDR_OFS    12'h008
`define SDT_IRQ_OFS      12'h00c
`define SDT_IMASK_OFS    12'h010
`define SDT_PINFO_OFS    12'h014
`define SDT_DINFO_OFS    12'h018
`define SDT_MODLEN_OFS   12'h01c
`define SDT_MODDAT_OFS   12'h020
`define SDT_SEND_OFS     12'h024

// ****************************************************************
// Control register fields
// ****************************************************************
`define SDT_CTRL_REPARAM 0
`define SDT_CTRL_STATIC  1
`define SDT_CTRL_RESPMON 2
`define SDT_CTRL_DISABLE 3
`define SDT_CTRL_RUNSTOP 4

// ****************************************************************
// Send command encodings
// ****************************************************************
`define SDT_SEND_NONE    2'h0
`define SDT_SEND_DIAG    2'h1
`define SDT_SEND_PROC    2'h2

// ****************************************************************
// Telegram constants
// ****************************************************************
`define SDT_HDR_LEN      8'h06
`define SDT_MOD_MAX      8'h0d
`define SDT_INT_MAX      8'h14
`define SDT_DIAG_CODE    8'h01
`define SDT_PROC_CODE    8'h02
`define SDT_NO_MASTER    8'hff
`define SDT_PROC_BODY    8'h04
`define SDT_DIAG_BODY    8'h10
`define SDT_DIAG_NZ      8'h04

// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define SDT_IRQ_DONE     0
`define SDT_IRQ_OVF      1
`define SDT_IRQ_FREEZE   2
`define SDT_IRQ_SYNC     3

`endif

// >>> rtl/sdt_mem.v
/*
 * Small synchronous memory holding the module status bytes.
 * Assumes a single clock; read data are registered.
 */
`timescale 1ns/1ps
module sdt_mem #(
	parameter AW = 4,
	parameter DW = 8
) (
	input  wire          clk,
	input  wire          we,
	input  wire [AW-1:0] waddr,
	input  wire [DW-1:0] wdata,
	input  wire [AW-1:0] raddr,
	output reg  [DW-1:0] rdata_q
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata_q <= mem[raddr];
	end
endmodule // sdt_mem

// >>> sim/sdt_checker.sv
/* Port checker for sdt_framer, bound at the foot of this file.
   Assumes one clock pclk and async active-low presetn. */
`timescale 1ns/1ps
module sdt_checker #(
	parameter [7:0] MAKER_HI = 8'h5a,
	parameter [7:0] MAKER_LO = 8'ha5
) (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        freeze_in,
	input wire        sync_in,
	input wire [7:0]  tx_data,
	input wire        tx_valid,
	input wire        tx_last,
	input wire        tx_ready,
	input wire        irq
);
	reg [5:0] idx_q;
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			idx_q <= 6'h00;
		else if (tx_valid && tx_ready)
			idx_q <= tx_last ? 6'h00 : idx_q + 6'h01;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	tx_hold_a: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("tx byte changed before accept");
	st2_fixed_a: assert property (
		tx_valid && idx_q == 6'h01 |-> tx_data[2] && !tx_data[6])
		else $error("status byte 1 fixed bits wrong");
	st3_zero_a: assert property (
		tx_valid && idx_q == 6'h02 |-> tx_data[6:0] == 7'h00)
		else $error("status byte 2 low bits not zero");
	maker_code_a: assert property (
		tx_valid && (idx_q == 6'h04 || idx_q == 6'h05) |->
		tx_data == (idx_q == 6'h04 ? MAKER_HI : MAKER_LO))
		else $error("maker code byte wrong");
	tel_len_a: assert property (
		tx_valid |-> idx_q < 6'h27)
		else $error("telegram too long");
	ready_one_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	ready_cause_a: assert property (pready |-> $past(psel && penable))
		else $error("pready without access");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	cover property (tx_valid && tx_ready && tx_last);
	cover property (pslverr);
	cover property (irq);
endmodule // sdt_checker

bind sdt_framer sdt_checker #(.MAKER_HI(MAKER_HI), .MAKER_LO(MAKER_LO))
	i_sdt_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.freeze_in(freeze_in), .sync_in(sync_in), .tx_data(tx_data),
	.tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
	.irq(irq));

// >>> sim/sdt_sink.sv
/* Model of the master side that takes telegram bytes.
   Assumes the framer's valid/ready byte stream on pclk. */
`timescale 1ns/1ps
module sdt_sink (
	input  wire       pclk,
	input  wire       presetn,
	input  wire [7:0] tx_data,
	input  wire       tx_valid,
	input  wire       tx_last,
	input  wire       stall,
	output reg        tx_ready
);
	reg [7:0] rx_q [0:63];
	integer   cnt_q;
	integer   len_q;
	integer   n_tel;
	// Whole telegram kept, count of telegrams so none is missed
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q <= 0;
			len_q <= 0;
			n_tel <= 0;
			tx_ready <= 1'b0;
		end
		else
		begin
			// Stall drops ready every other cycle
			tx_ready <= !stall || !tx_ready;
			if (tx_valid && tx_ready)
			begin
				rx_q[cnt_q[5:0]] <= tx_data;
				cnt_q <= tx_last ? 0 : cnt_q + 1;
				if (tx_last)
					len_q <= cnt_q + 1;
				if (tx_last)
					n_tel <= n_tel + 1;
			end
		end
	end
endmodule // sdt_sink

// >>> sim/sdt_framer_tb.sv
/* Self-checking bench for the telegram framer over APB.
   Assumes rtl/ on the include path and sdt_sink as far side. */
`timescale 1ns/1ps
`include "sdt_regs.vh"
module sdt_framer_tb;
	reg         pclk, presetn, psel, penable, pwrite;
	reg  [11:0] paddr;
	reg  [31:0] pwdata, rd;
	reg         freeze_in, sync_in, stall, er;
	wire [31:0] prdata;
	wire [7:0]  tx_data;
	wire        pready, pslverr, tx_valid, tx_last, tx_ready, irq;
	reg  [7:0]  ex [0:25];
	integer     n_mismatch, tests_run, i, k;

	sdt_framer i_sdt_framer (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.freeze_in(freeze_in), .sync_in(sync_in), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
		.irq(irq));
	sdt_sink i_sdt_sink (.pclk(pclk), .presetn(presetn), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_last(tx_last), .stall(stall),
		.tx_ready(tx_ready));

	task stop_test;
	begin
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask

	task chk(input string nm, input [31:0] e, input [31:0] g);
	begin
		tests_run++;
		if (g !== e)
		begin
			$display("MISMATCH %s exp %h got %h", nm, e, g);
			n_mismatch++;
		end
	end
	endtask

	task tmo;
	begin
		chk("wait", 32'h1, 32'h0);
		stop_test;
	end
	endtask

	// Holds the request until pready is seen at an edge
	task apb(input w, input [11:0] a, input [31:0] d);
	begin
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50 && pready !== 1'b1; k++)
			@(posedge pclk);
		if (k == 50)
			tmo;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask

	task wait_tel;
		integer n0;
	begin
		n0 = i_sdt_sink.n_tel;
		for (k = 0; k < 500 && i_sdt_sink.n_tel == n0; k++)
			@(posedge pclk);
		if (k == 500)
			tmo;
	end
	endtask

	// Whole telegram compared, status byte 0 included
	task cmp(input integer n);
	begin
		chk("length", n, i_sdt_sink.len_q);
		for (i = 0; i < n; i++)
			chk($sformatf("byte %0d", i), ex[i],
				i_sdt_sink.rx_q[i]);
	end
	endtask

	task hdr(input [7:0] b1, input [7:0] b3);
	begin
		for (i = 0; i < 26; i++)
			ex[i] = 8'h00;
		ex[1] = b1;
		ex[3] = b3;
		ex[4] = 8'h5a;
		ex[5] = 8'ha5;
	end
	endtask

	task t_proc;
	begin
		apb(0, `SDT_CTRL_OFS, 0);
		chk("ctrl reset", 32'h4, rd);
		apb(0, 12'h040, 0);
		chk("unmapped err", 32'h1, er);
		apb(1, `SDT_IMASK_OFS, 32'h1);
		apb(1, `SDT_PINFO_OFS, 32'h11223344);
		apb(1, `SDT_MODLEN_OFS, 32'h2);
		apb(1, `SDT_MODDAT_OFS, 32'h0a1);
		apb(1, `SDT_MODDAT_OFS, 32'h1b2);
		apb(1, `SDT_SEND_OFS, 32'h2);
		wait_tel;
		hdr(8'h0c, 8'hff);
		{ex[6], ex[7], ex[8], ex[9]} = 32'ha1b2_0802;
		{ex[12], ex[13], ex[14], ex[15]} = 32'h11223344;
		cmp(16);
		repeat (2) @(posedge pclk);
		chk("irq on", 32'h1, irq);
		apb(0, `SDT_IRQ_OFS, 0);
		chk("irq done bit", 32'h1, rd[0]);
		repeat (3) @(posedge pclk);
		chk("irq cleared", 32'h0, irq);
	end
	endtask

	task t_diag(input rs);
	begin
		apb(1, `SDT_IMASK_OFS, 0);
		freeze_in <= 1'b1;
		sync_in <= 1'b1;
		apb(1, `SDT_CTRL_OFS, {27'h0, rs, 4'hb});
		freeze_in <= 1'b0;
		sync_in <= 1'b0;
		apb(1, `SDT_MADDR_OFS, 32'h5);
		apb(1, `SDT_DINFO_OFS, 32'hdeadbeef);
		apb(1, `SDT_MODLEN_OFS, 0);
		stall <= 1'b1;
		apb(1, `SDT_SEND_OFS, 32'h1);
		wait_tel;
		stall <= 1'b0;
		hdr(8'hb7, 8'h05);
		ex[0] = {4'h0, rs, 3'h0};
		{ex[6], ex[7], ex[10], ex[11]} = 32'h1401_dead;
		{ex[12], ex[13]} = 16'hbeef;
		cmp(26);
		chk("run stop", rs, i_sdt_sink.rx_q[0][3]);
		chk("irq masked", 32'h0, irq);
	end
	endtask

	task t_ovf;
	begin
		repeat (3) apb(1, `SDT_SEND_OFS, 32'h2);
		repeat (300) @(posedge pclk);
		apb(0, `SDT_STAT_OFS, 0);
		chk("ovf bits", 32'h3, {rd[23], rd[2]});
		apb(1, `SDT_STAT_OFS, 32'h7);
		apb(0, `SDT_STAT_OFS, 0);
		chk("stat clear", 32'h0, {rd[23], rd[2:0]});
		apb(1, `SDT_MODLEN_OFS, 32'h20);
		apb(0, `SDT_MODLEN_OFS, 0);
		chk("modlen clamp", 32'hd, rd);
		apb(1, `SDT_SEND_OFS, 32'h3);
		apb(0, `SDT_SEND_OFS, 0);
		chk("send refused", 32'h0, rd);
	end
	endtask

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	initial
	begin
		{presetn, psel, penable, pwrite, freeze_in, sync_in, stall} = 7'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		n_mismatch = 0;
		tests_run = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_proc;
		t_diag(1'b1);
		t_diag(1'b0);
		t_ovf;
		stop_test;
	end
endmodule // sdt_framer_tb
